/* File: src/hib_map.svh */
`ifndef HIB_MAP_SVH
`define HIB_MAP_SVH

// --------------------------------------------
// register byte offsets
// --------------------------------------------
`define HIB_OFF_RTC      12'h000
`define HIB_OFF_MATCH0   12'h004
`define HIB_OFF_MATCH1   12'h008
`define HIB_OFF_TRIM     12'h00c
`define HIB_OFF_CTRL     12'h010
`define HIB_OFF_IRQ_EN   12'h014
`define HIB_OFF_IRQ_RAW  12'h018
`define HIB_OFF_IRQ_MASK 12'h01c
`define HIB_OFF_IRQ_CLR  12'h020
`define HIB_OFF_CLK_RATE 12'h024
`define HIB_OFF_STATUS   12'h028
`define HIB_DATA_PAGE    4'h1

// --------------------------------------------
// field widths and positions
// --------------------------------------------
`define HIB_CTRL_W       7
`define HIB_CTRL_REQ_BIT 7
`define HIB_IRQ_W        4

// --------------------------------------------
// reset values, counts and response codes
// --------------------------------------------
`define HIB_TRIM_RST     16'h7fff
`define HIB_RATE_RST     32'h0bebc200
`define HIB_XTAL_DIV_END 7'h7f
`define HIB_RESP_OKAY    2'b00
`define HIB_RESP_SLVERR  2'b10

`endif

/* File: src/hib_pkg.sv */
package hib_pkg;

    typedef enum logic [1:0]
    {
        lowbatt_off              = 2'b00,
        lowbatt_detect_only      = 2'b01,
        lowbatt_detect_and_abort = 2'b11
    } hib_lowbatt_type;

    typedef struct packed
    {
        logic [1:0] lowbatt_mode;
        logic       wake_rtc_en;
        logic       wake_pin_en;
        logic       timebase_crystal_div;
        logic       rtc_en;
        logic       module_en;
    } hib_ctrl_type;

    typedef struct packed
    {
        logic match1;
        logic match0;
        logic irq_lowbatt;
        logic pin_wake;
    } hib_irq_type;

    typedef enum logic [1:0]
    {
        st_awake  = 2'b01,
        st_asleep = 2'b10
    } hib_state_type;

endpackage

/* File: src/hib_tick.sv */
`timescale 1ns/1ps
`include "hib_map.svh"

module hib_tick
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // timebase pins
    input  wire logic        osc_pin,
    input  wire logic        xtal_pin,
    // control
    input  wire logic        run,
    input  wire logic        crystal_sel,
    input  wire logic [15:0] trim,
    // one pulse per counter step
    output logic             sec_tick
);
    import hib_pkg::*;

    logic [1:0]  osc_sync;
    logic [1:0]  xtal_sync;
    logic        osc_last;
    logic        xtal_last;
    logic [6:0]  div_cnt;
    logic [15:0] sub_cnt;

    // --------------------------------------------
    // timebase selection
    // --------------------------------------------
    wire osc_edge  = osc_sync[1] & ~osc_last;
    wire xtal_edge = xtal_sync[1] & ~xtal_last;
    wire div_wrap  = xtal_edge && (div_cnt == `HIB_XTAL_DIV_END);
    wire base_tick = crystal_sel ? div_wrap : osc_edge;
    wire sub_wrap  = base_tick && (sub_cnt >= trim);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osc_sync  <= 2'h0;
            xtal_sync <= 2'h0;
            osc_last  <= 1'b0;
            xtal_last <= 1'b0;
        end
        else
        begin
            osc_sync  <= {osc_sync[0], osc_pin};
            xtal_sync <= {xtal_sync[0], xtal_pin};
            osc_last  <= osc_sync[1];
            xtal_last <= xtal_sync[1];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run)
            div_cnt <= 7'h00;
        else if (xtal_edge)
            div_cnt <= div_cnt + 7'h01;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run)
            sub_cnt <= 16'h0000;
        else if (sub_wrap)
            sub_cnt <= 16'h0000;
        else if (base_tick)
            sub_cnt <= sub_cnt + 16'h0001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sec_tick <= 1'b0;
        else
            sec_tick <= run && sub_wrap;
    end

endmodule

/* File: src/hib_controller.sv */
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "hib_map.svh"

module hib_controller
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // pins
    input  wire logic        osc_pin,
    input  wire logic        xtal_pin,
    input  wire logic        wake_pin,
    input  wire logic        lowbatt_pin,
    output hib_pkg::hib_state_type state,
    output logic             irq
);
    import hib_pkg::*;

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr[11:2] == off[11:2]);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[11:8] == `HIB_DATA_PAGE) || (a[11:2] <= `HIB_OFF_STATUS >> 2);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] val,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            merge[8*i +: 8] = strb[i] ? val[8*i +: 8] : cur[8*i +: 8];
    endfunction

    logic [31:0]   keep_mem [0:63];
    logic [31:0]   rtc;
    logic [31:0]   match0;
    logic [31:0]   match1;
    logic [15:0]   trim;
    logic [31:0]   clk_rate;
    hib_ctrl_type  ctrl;
    hib_irq_type   irq_en;
    hib_irq_type   irq_raw;
    hib_state_type next_state;
    logic [11:0]   aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          aw_held;
    logic          w_held;
    logic          rtc_moved;
    logic [1:0]    wake_sync;
    logic [1:0]    batt_sync;
    logic          wake_last;
    logic          sec_tick;

    // --------------------------------------------
    // decode
    // --------------------------------------------
    wire          wr_fire  = aw_held && w_held && !bvalid;
    wire          wr_mem   = wr_fire && (aw_addr[11:8] == `HIB_DATA_PAGE);
    wire          wr_rtc   = wr_fire && hit(aw_addr, `HIB_OFF_RTC);
    wire          wr_ctrl  = wr_fire && hit(aw_addr, `HIB_OFF_CTRL);
    wire          wr_clr   = wr_fire && hit(aw_addr, `HIB_OFF_IRQ_CLR) && w_strb[0];
    wire          ar_fire  = arvalid && arready;
    wire          ar_mem   = (araddr[11:8] == `HIB_DATA_PAGE);
    wire [31:0]   wr_ctrlv = merge({25'h0000000, ctrl}, w_data, w_strb);
    wire [31:0]   wr_trimv = merge({16'h0000, trim}, w_data, w_strb);
    wire [31:0]   wr_env   = merge({28'h0000000, irq_en}, w_data, w_strb);
    wire [31:0]   rd_mux   =
        ar_mem                           ? keep_mem[araddr[7:2]] :
        hit(araddr, `HIB_OFF_RTC)        ? rtc :
        hit(araddr, `HIB_OFF_MATCH0)     ? match0 :
        hit(araddr, `HIB_OFF_MATCH1)     ? match1 :
        hit(araddr, `HIB_OFF_TRIM)       ? {16'h0000, trim} :
        hit(araddr, `HIB_OFF_CTRL)       ? {25'h0000000, ctrl} :
        hit(araddr, `HIB_OFF_IRQ_EN)     ? {28'h0000000, irq_en} :
        hit(araddr, `HIB_OFF_IRQ_RAW)    ? {28'h0000000, irq_raw} :
        hit(araddr, `HIB_OFF_IRQ_MASK)   ? {28'h0000000, irq_raw & irq_en} :
        hit(araddr, `HIB_OFF_CLK_RATE)   ? clk_rate :
        hit(araddr, `HIB_OFF_STATUS)     ? {30'h00000000, batt_sync[1], state[1]} :
        32'h00000000;

    // --------------------------------------------
    // events
    // --------------------------------------------
    wire         active    = ctrl.module_en;
    wire         rtc_run   = active && ctrl.rtc_en;
    wire         m0_evt    = active && rtc_moved && (rtc == match0);
    wire         m1_evt    = active && rtc_moved && (rtc == match1);
    wire         pin_evt   = active && wake_sync[1] && !wake_last;
    wire         batt_low  = active && batt_sync[1] && (ctrl.lowbatt_mode != lowbatt_off);
    wire         abort     = batt_low && (ctrl.lowbatt_mode == lowbatt_detect_and_abort);
    wire         req_fire  = wr_ctrl && active && w_strb[0] && w_data[`HIB_CTRL_REQ_BIT];
    wire         wake_now  = (ctrl.wake_pin_en && pin_evt) ||
                             (ctrl.wake_rtc_en && (m0_evt || m1_evt));
    hib_irq_type irq_set;
    hib_irq_type irq_clr;
    hib_irq_type next_raw;
    assign irq_set  = '{match1: m1_evt, match0: m0_evt, irq_lowbatt: batt_low, pin_wake: pin_evt};
    assign irq_clr  = wr_clr ? hib_irq_type'(w_data[3:0]) : hib_irq_type'(4'h0);
    assign next_raw = (irq_raw & ~irq_clr) | irq_set;

    // --------------------------------------------
    // axi4-lite slave
    // --------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b0;
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
        end
        else
        begin
            awready <= awvalid && !awready && !aw_held;
            if (awvalid && awready)
                aw_addr <= awaddr;
            aw_held <= (awvalid && awready) || (aw_held && !wr_fire);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready <= 1'b0;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end
        else
        begin
            wready <= wvalid && !wready && !w_held;
            if (wvalid && wready)
            begin
                w_data <= wdata;
                w_strb <= wstrb;
            end
            w_held <= (wvalid && wready) || (w_held && !wr_fire);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= `HIB_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            bresp  <= mapped(aw_addr) ? `HIB_RESP_OKAY : `HIB_RESP_SLVERR;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `HIB_RESP_OKAY;
        end
        else
        begin
            arready <= arvalid && !arready && !rvalid;
            if (ar_fire)
            begin
                rvalid <= 1'b1;
                rdata  <= rd_mux;
                rresp  <= mapped(araddr) ? `HIB_RESP_OKAY : `HIB_RESP_SLVERR;
            end
            else if (rready)
                rvalid <= 1'b0;
        end
    end

    // --------------------------------------------
    // registers
    // --------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (wr_mem)
            keep_mem[aw_addr[7:2]] <= merge(keep_mem[aw_addr[7:2]], w_data, w_strb);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            match0   <= 32'h00000000;
            match1   <= 32'h00000000;
            trim     <= `HIB_TRIM_RST;
            clk_rate <= `HIB_RATE_RST;
            ctrl     <= hib_ctrl_type'(7'h00);
            irq_en   <= hib_irq_type'(4'h0);
        end
        else if (wr_fire)
        begin
            if (hit(aw_addr, `HIB_OFF_MATCH0))
                match0 <= merge(match0, w_data, w_strb);
            if (hit(aw_addr, `HIB_OFF_MATCH1))
                match1 <= merge(match1, w_data, w_strb);
            if (hit(aw_addr, `HIB_OFF_TRIM))
                trim <= wr_trimv[15:0];
            if (hit(aw_addr, `HIB_OFF_CLK_RATE))
                clk_rate <= merge(clk_rate, w_data, w_strb);
            if (wr_ctrl)
                ctrl <= hib_ctrl_type'(wr_ctrlv[`HIB_CTRL_W-1:0]);
            if (hit(aw_addr, `HIB_OFF_IRQ_EN))
                irq_en <= hib_irq_type'(wr_env[`HIB_IRQ_W-1:0]);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rtc       <= 32'h00000000;
            rtc_moved <= 1'b0;
        end
        else
        begin
            if (wr_rtc)
                rtc <= merge(rtc, w_data, w_strb);
            else if (rtc_run && sec_tick)
                rtc <= rtc + 32'h00000001;
            rtc_moved <= !wr_rtc && rtc_run && sec_tick;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_sync <= 2'h0;
            batt_sync <= 2'h0;
            wake_last <= 1'b0;
            irq_raw   <= hib_irq_type'(4'h0);
            irq       <= 1'b0;
        end
        else
        begin
            wake_sync <= {wake_sync[0], wake_pin};
            batt_sync <= {batt_sync[0], lowbatt_pin};
            wake_last <= wake_sync[1];
            irq_raw   <= next_raw;
            irq       <= active && |(next_raw & irq_en);
        end
    end

    // --------------------------------------------
    // hibernation sequence
    // --------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            st_awake:
                if (req_fire && !abort)
                    next_state = st_asleep;
            st_asleep:
                if (wake_now)
                    next_state = st_awake;
            default:
                next_state = st_awake;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= st_awake;
        else
            state <= next_state;
    end

    hib_tick u_tick
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .osc_pin     (osc_pin),
        .xtal_pin    (xtal_pin),
        .run         (rtc_run),
        .crystal_sel (ctrl.timebase_crystal_div),
        .trim        (trim),
        .sec_tick    (sec_tick)
    );

    // --------------------------------------------
    // assertions
    // --------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_req_ok;
        req_fire && !abort && state == st_awake;
    endsequence
    sequence s_req_abort;
        req_fire && abort && state == st_awake;
    endsequence
    sequence s_wake;
        state == st_asleep && wake_now;
    endsequence

    a_rtc_load_word: assert property (wr_rtc && w_strb == 4'hf |=> rtc == $past(w_data))
        else $error("counter write not loaded");
    a_rtc_held_stop: assert property (!rtc_run && !wr_rtc |=> $stable(rtc))
        else $error("counter moved while stopped");
    a_match0_flag: assert property (m0_evt |=> irq_raw.match0)
        else $error("match zero not flagged");
    a_irq_pending_hold: assert property (irq_raw.match1 && !(wr_clr && w_data[3]) |=> irq_raw.match1)
        else $error("pending match one lost");
    a_masked_status_read: assert property (ar_fire && hit(araddr, `HIB_OFF_IRQ_MASK)
        |=> rvalid && rdata[3:0] == ($past(irq_raw) & $past(irq_en)))
        else $error("masked status wrong");
    a_hib_enter_off: assert property (s_req_ok |=> state == st_asleep)
        else $error("regulator not dropped on request");
    a_lowbatt_abort_hold: assert property (s_req_abort |=> (state == st_awake) [*2])
        else $error("hibernation not aborted on low battery");
    a_wake_reg_on: assert property (s_wake |=> (state == st_awake) [*2])
        else $error("regulator not restored on wake");
    a_disabled_no_set: assert property (!active |=> (irq_raw & ~$past(irq_raw)) == 4'h0)
        else $error("source set while disabled");

endmodule

/* File: tb/hib_far_side.sv */
`timescale 1ns/1ps

module hib_far_side
#(
    parameter real OSC_HALF_NS  = 15258.789,
    parameter real XTAL_HALF_NS = 119.209
)
(
    // bench controls
    input  wire logic              osc_on,
    input  wire logic              xtal_on,
    input  wire logic              batt_low,
    input  wire logic              wake_req,
    // regulator enable
    input  hib_pkg::hib_state_type state,
    // pins and supply
    output logic                   osc_pin,
    output logic                   xtal_pin,
    output logic                   wake_pin,
    output logic                   lowbatt_pin,
    output logic                   power_on
);
    import hib_pkg::*;

    // ----------------------------------------
    // timebases, still while switched off
    // ----------------------------------------
    initial
    begin
        osc_pin = 1'b0;
        forever
        begin
            #(OSC_HALF_NS);
            osc_pin = osc_on & ~osc_pin;
        end
    end

    initial
    begin
        xtal_pin = 1'b0;
        forever
        begin
            #(XTAL_HALF_NS);
            xtal_pin = xtal_on & ~xtal_pin;
        end
    end

    // ----------------------------------------
    // pins and regulator
    // ----------------------------------------
    assign wake_pin    = wake_req;
    assign lowbatt_pin = batt_low;
    assign power_on    = (state == st_awake);
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "hib_map.svh"

module tb;
    import hib_pkg::*;

    localparam int TICK_CYC = 6104;

    logic          aclk, aresetn, irq, power_on;
    logic [11:0]   awaddr, araddr;
    logic [31:0]   wdata, rdata, rd_data, held;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, last_resp;
    logic          awvalid, awready, wvalid, wready, bvalid, bready;
    logic          arvalid, arready, rvalid, rready;
    logic          osc_pin, xtal_pin, wake_pin, lowbatt_pin;
    logic          osc_on, xtal_on, batt_low, wake_req;
    hib_state_type state;
    int            num_errors, samples_checked;

    hib_controller uut
    (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .osc_pin(osc_pin), .xtal_pin(xtal_pin),
        .wake_pin(wake_pin), .lowbatt_pin(lowbatt_pin), .state(state), .irq(irq)
    );

    hib_far_side far
    (
        .osc_on(osc_on), .xtal_on(xtal_on), .batt_low(batt_low), .wake_req(wake_req), .state(state),
        .osc_pin(osc_pin), .xtal_pin(xtal_pin), .wake_pin(wake_pin), .lowbatt_pin(lowbatt_pin),
        .power_on(power_on)
    );

    initial
    begin
        aclk = 1'b0;
        forever
            #2.5 aclk = ~aclk;
    end

    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rng(string nm, logic [31:0] lo, logic [31:0] hi, logic [31:0] got);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            num_errors++;
            $display("MISMATCH %s expected %0d to %0d seen %h", nm, lo, hi, got);
        end
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s = 4'hf);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready    <= 1'b0;
        last_resp = bresp;
    endtask

    task automatic rd(logic [11:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready    <= 1'b0;
        rd_data   = rdata;
        last_resp = rresp;
    endtask

    task automatic rchk(string nm, logic [11:0] a, logic [31:0] exp);
        rd(a);
        chk(nm, exp, rd_data);
    endtask

    task automatic pulse_wake;
        @(posedge aclk);
        wake_req <= 1'b1;
        repeat (8) @(posedge aclk);
        wake_req <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #(460_000);
        num_errors++;
        close_out();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, wake_req, batt_low, xtal_on} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        osc_on = 1'b1;
        num_errors = 0;
        samples_checked = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("trim reset", `HIB_OFF_TRIM, 32'h0000_7fff);
        rchk("rate reset", `HIB_OFF_CLK_RATE, 32'h0bebc200);
        rchk("ctrl reset", `HIB_OFF_CTRL, 32'h0);
        chk("state reset", 32'(st_awake), 32'(state));
        wr(12'h030, 32'hffff_ffff);
        chk("unmapped bresp", 32'(`HIB_RESP_SLVERR), 32'(last_resp));
        rchk("unmapped rdata", 12'h030, 32'h0);
        chk("unmapped rresp", 32'(`HIB_RESP_SLVERR), 32'(last_resp));
        wr(`HIB_OFF_CLK_RATE, 32'h05f5_e100);
        chk("mapped bresp", 32'(`HIB_RESP_OKAY), 32'(last_resp));
        rchk("rate", `HIB_OFF_CLK_RATE, 32'h05f5_e100);
        chk("mapped rresp", 32'(`HIB_RESP_OKAY), 32'(last_resp));
        for (int i = 0; i < 3; i++)
            wr(12'(4 * i), 32'hc0de_0000 + i);
        for (int i = 0; i < 3; i++)
            rchk("counter or match", 12'(4 * i), 32'hc0de_0000 + i);
        wr(`HIB_OFF_TRIM, 32'h0000_1234);
        rchk("trim", `HIB_OFF_TRIM, 32'h0000_1234);
        wr(`HIB_OFF_TRIM, 32'h0);
        wr(`HIB_OFF_IRQ_EN, 32'ha);
        rchk("irq enable", `HIB_OFF_IRQ_EN, 32'ha);
        wr(`HIB_OFF_IRQ_EN, 32'h5);
        rchk("irq enable", `HIB_OFF_IRQ_EN, 32'h5);
        wr(`HIB_OFF_CTRL, 32'h18);
        rchk("wake config", `HIB_OFF_CTRL, 32'h18);
        $display("test registers done");
        for (int i = 0; i < 64; i++)
            wr(12'h100 + 12'(4 * i), {8'h5a, 8'(i), 16'(~i)});
        for (int i = 0; i < 64; i++)
            rchk("store word", 12'h100 + 12'(4 * i), {8'h5a, 8'(i), 16'(~i)});
        wr(12'h100, 32'hffff_ffff);
        wr(12'h100, 32'h1122_3344, 4'b0101);
        rchk("store lanes", 12'h100, 32'hff22_ff44);
        $display("test store done");
        wr(`HIB_OFF_CTRL, 32'h02);
        wr(`HIB_OFF_RTC, 32'h5);
        wr(`HIB_OFF_IRQ_EN, 32'hf);
        pulse_wake();
        repeat (TICK_CYC + 100) @(posedge aclk);
        rchk("counter disabled", `HIB_OFF_RTC, 32'h5);
        rchk("raw disabled", `HIB_OFF_IRQ_RAW, 32'h0);
        chk("irq disabled", 32'h0, 32'(irq));
        wr(`HIB_OFF_CTRL, 32'h01);
        wr(`HIB_OFF_CTRL, 32'h03);
        repeat (3 * TICK_CYC) @(posedge aclk);
        rd(`HIB_OFF_RTC);
        rng("counter running", 32'd7, 32'd9, rd_data);
        wr(`HIB_OFF_CTRL, 32'h01);
        rd(`HIB_OFF_RTC);
        held = rd_data;
        repeat (TICK_CYC + 100) @(posedge aclk);
        rchk("counter stopped", `HIB_OFF_RTC, held);
        $display("test counter done");
        wr(`HIB_OFF_IRQ_CLR, 32'hf);
        wr(`HIB_OFF_RTC, 32'h0);
        wr(`HIB_OFF_MATCH0, 32'h1);
        wr(`HIB_OFF_MATCH1, 32'h2);
        wr(`HIB_OFF_IRQ_EN, 32'hc);
        wr(`HIB_OFF_CTRL, 32'h03);
        repeat (3 * TICK_CYC) @(posedge aclk);
        wr(`HIB_OFF_CTRL, 32'h01);
        rchk("match raw", `HIB_OFF_IRQ_RAW, 32'hc);
        chk("irq match", 32'h1, 32'(irq));
        wr(`HIB_OFF_IRQ_EN, 32'h4);
        rchk("masked", `HIB_OFF_IRQ_MASK, 32'h4);
        wr(`HIB_OFF_IRQ_CLR, 32'h4);
        rchk("raw after clear", `HIB_OFF_IRQ_RAW, 32'h8);
        chk("irq cleared", 32'h0, 32'(irq));
        wr(`HIB_OFF_IRQ_CLR, 32'h8);
        rchk("raw all clear", `HIB_OFF_IRQ_RAW, 32'h0);
        wr(`HIB_OFF_IRQ_EN, 32'h1);
        pulse_wake();
        rchk("pin raw", `HIB_OFF_IRQ_RAW, 32'h1);
        chk("irq pin", 32'h1, 32'(irq));
        wr(`HIB_OFF_IRQ_CLR, 32'h1);
        $display("test interrupts done");
        wr(`HIB_OFF_CTRL, 32'h21);
        batt_low <= 1'b1;
        repeat (8) @(posedge aclk);
        rchk("lowbatt raw", `HIB_OFF_IRQ_RAW, 32'h2);
        rchk("lowbatt status", `HIB_OFF_STATUS, 32'h2);
        wr(`HIB_OFF_CTRL, 32'h61);
        wr(`HIB_OFF_CTRL, 32'he1);
        repeat (8) @(posedge aclk);
        chk("abort state", 32'(st_awake), 32'(state));
        rchk("abort status", `HIB_OFF_STATUS, 32'h2);
        batt_low <= 1'b0;
        repeat (8) @(posedge aclk);
        wr(`HIB_OFF_IRQ_CLR, 32'h2);
        rchk("lowbatt cleared", `HIB_OFF_IRQ_RAW, 32'h0);
        $display("test low battery done");
        wr(12'h11c, 32'hfeed_0007);
        wr(`HIB_OFF_CTRL, 32'h09);
        wr(`HIB_OFF_CTRL, 32'h89);
        repeat (8) @(posedge aclk);
        chk("asleep", 32'(st_asleep), 32'(state));
        chk("power off", 32'h0, 32'(power_on));
        rchk("asleep status", `HIB_OFF_STATUS, 32'h1);
        rchk("store kept", 12'h11c, 32'hfeed_0007);
        pulse_wake();
        chk("awake", 32'(st_awake), 32'(state));
        chk("power on", 32'h1, 32'(power_on));
        rchk("still active", `HIB_OFF_CTRL, 32'h09);
        rchk("wake cause", `HIB_OFF_IRQ_RAW, 32'h1);
        wr(`HIB_OFF_IRQ_CLR, 32'hf);
        $display("test hibernate done");
        wr(`HIB_OFF_RTC, 32'h0);
        wr(`HIB_OFF_MATCH0, 32'h2);
        wr(`HIB_OFF_CTRL, 32'h13);
        wr(`HIB_OFF_CTRL, 32'h93);
        chk("match asleep", 32'(st_asleep), 32'(state));
        repeat (2 * TICK_CYC + 100) @(posedge aclk);
        chk("match wake", 32'(st_awake), 32'(state));
        chk("match power on", 32'h1, 32'(power_on));
        $display("test match wake done");
        osc_on  <= 1'b0;
        xtal_on <= 1'b1;
        wr(`HIB_OFF_CTRL, 32'h0);
        wr(`HIB_OFF_CTRL, 32'h01);
        repeat (200) @(posedge aclk);
        wr(`HIB_OFF_CTRL, 32'h07);
        wr(`HIB_OFF_RTC, 32'h0);
        repeat (3 * TICK_CYC) @(posedge aclk);
        rd(`HIB_OFF_RTC);
        rng("crystal counter", 32'd2, 32'd4, rd_data);
        $display("test crystal done");
        close_out();
    end
endmodule
